// ===== logic/lsbt_pkg.sv
// Function
// (R01) Each of the seven sinks has one enable bit, bits 0 to 6 for sinks 1 to 7; 1 lights it, 0 darkens it.
// (R02) Bits 7:6 of the first timing register pick the shared on time: 0.2, 0.6, 0.8 or 1.2 s.
// (R03) The on time applies only to an enabled sink whose off-time field is nonzero, which then stays lit that long and goes dark.
// (R04) The off-time fields of sinks 7, 6 and 5 sit in bits 5:4, 3:2 and 1:0 and decode alike: off, 0.6, 1.2 or 1.8 s.
// (R05) With a nonzero off time the sink stays dark for that time, relights for the on time, and repeats while enabled.
// (R06) An enabled sink whose off-time field is 00 stays lit without blinking.
// (R07) The enable bits live in the register at address 0x10, and its bit 7 is reserved.
// (R08) All intervals come from one shared time base, and each sink keeps its own phase so sinks blink independently.
package lsbt_pkg;
    localparam logic [7:0] LSBT_SINK_ENABLE_ADDR = 8'h10;
    localparam logic [7:0] LSBT_BLINK_TIMING_ONE_ADDR = 8'h11;
    localparam logic [7:0] LSBT_SINK_ENABLE_RESET = 8'h00;
    localparam logic [7:0] LSBT_BLINK_TIMING_ONE_RESET = 8'h00;
    localparam logic [7:0] LSBT_SINK_ENABLE_MASK = 8'h7F;
    localparam int LSBT_SINKS = 7;
    localparam int LSBT_ON_TIME_LSB = 6;
    localparam int LSBT_FIRST_TIMED_SINK = 4;
    localparam int LSBT_FIELD_W = 2;
    localparam int LSBT_CLK_PERIOD_NS = 5;
    localparam int LSBT_TICK_TIME_MS = 200;
    localparam int LSBT_TICK_CYCLES = LSBT_TICK_TIME_MS * 1000000 / LSBT_CLK_PERIOD_NS;
    localparam int LSBT_ON_00_MS = 200;
    localparam int LSBT_ON_01_MS = 600;
    localparam int LSBT_ON_10_MS = 800;
    localparam int LSBT_ON_11_MS = 1200;
    localparam int LSBT_DARK_01_MS = 600;
    localparam int LSBT_DARK_10_MS = 1200;
    localparam int LSBT_DARK_11_MS = 1800;

    typedef enum logic [1:0] {
        LSBT_IDLE = 2'b00,
        LSBT_LIT = 2'b01,
        LSBT_DARK = 2'b10
    } lsbt_phase_t;

    function automatic logic [3:0] lsbt_on_ticks(input logic [1:0] code);
        int ms;
        unique case (code)
            2'h0: ms = LSBT_ON_00_MS;
            2'h1: ms = LSBT_ON_01_MS;
            2'h2: ms = LSBT_ON_10_MS;
            2'h3: ms = LSBT_ON_11_MS;
        endcase
        return 4'(ms / LSBT_TICK_TIME_MS);
    endfunction : lsbt_on_ticks

    function automatic logic [3:0] lsbt_dark_ticks(input logic [1:0] code);
        int ms;
        unique case (code)
            2'h0: ms = 0;
            2'h1: ms = LSBT_DARK_01_MS;
            2'h2: ms = LSBT_DARK_10_MS;
            2'h3: ms = LSBT_DARK_11_MS;
        endcase
        return 4'(ms / LSBT_TICK_TIME_MS);
    endfunction : lsbt_dark_ticks
endpackage : lsbt_pkg

// ===== logic/lsbt_sink_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lsbt_sink_if;
    logic tick;
    logic enable;
    logic [1:0] on_code;
    logic [1:0] dark_code;
    logic lit;
    modport ctrl (output tick, output enable, output on_code, output dark_code, input lit);
    modport sink (input tick, input enable, input on_code, input dark_code, output lit);
endinterface : lsbt_sink_if
`default_nettype wire

// ===== logic/lsbt_sink.sv
`timescale 1ns/1ps
`default_nettype none
module lsbt_sink
    import lsbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    lsbt_sink_if.sink bus
);
    lsbt_phase_t phase;
    lsbt_phase_t next_phase;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] on_ticks;
    logic [3:0] dark_ticks;

    assign on_ticks = lsbt_on_ticks(bus.on_code); // [R02]
    assign dark_ticks = lsbt_dark_ticks(bus.dark_code); // [R04]

    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        if (!bus.enable) begin
            next_phase = LSBT_IDLE; // [R01]
        end else begin
            unique case (phase)
                LSBT_IDLE: begin
                    next_phase = LSBT_LIT; // [R01]
                    next_cnt = on_ticks;
                end
                LSBT_LIT: begin
                    if (bus.dark_code == 2'h0) begin
                        next_cnt = on_ticks; // [R06]
                    end else if (bus.tick) begin
                        if (cnt <= 4'h1) begin
                            next_phase = LSBT_DARK; // [R03]
                            next_cnt = dark_ticks;
                        end else begin
                            next_cnt = cnt - 4'h1; // [R08]
                        end
                    end
                end
                LSBT_DARK: begin
                    if (bus.dark_code == 2'h0) begin
                        next_phase = LSBT_LIT; // [R06]
                        next_cnt = on_ticks;
                    end else if (bus.tick) begin
                        if (cnt <= 4'h1) begin
                            next_phase = LSBT_LIT; // [R05]
                            next_cnt = on_ticks;
                        end else begin
                            next_cnt = cnt - 4'h1; // [R08]
                        end
                    end
                end
                default: begin
                    next_phase = LSBT_IDLE;
                end
            endcase
        end
    end

    // each sink owns its phase, so sinks enabled in different tick periods stay out of step
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= LSBT_IDLE;
            cnt <= 4'h0;
        end else begin
            phase <= next_phase; // [R08]
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.lit <= 1'b0;
        end else begin
            bus.lit <= (next_phase == LSBT_LIT);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence last_lit_tick_s;
        phase == LSBT_LIT && bus.enable && bus.dark_code != 2'h0 && bus.tick && cnt <= 4'h1;
    endsequence
    sequence last_dark_tick_s;
        phase == LSBT_DARK && bus.enable && bus.dark_code != 2'h0 && bus.tick && cnt <= 4'h1;
    endsequence

    disabled_dark_a: assert property (!bus.enable |=> !bus.lit) // [R01]
        else $error("disabled sink is lit");
    enable_lights_a: assert property ($rose(bus.enable) |=> bus.lit) // [R01]
        else $error("enabled sink did not light");
    steady_on_a: assert property (bus.enable && bus.dark_code == 2'h0 ##1 // [R06]
        bus.enable && bus.dark_code == 2'h0 |=> bus.lit)
        else $error("steady sink not lit");
    on_expiry_a: assert property (last_lit_tick_s |=> !bus.lit && cnt == $past(dark_ticks)) // [R03]
        else $error("on interval did not end in dark phase");
    dark_expiry_a: assert property (last_dark_tick_s |=> bus.lit && cnt == $past(on_ticks)) // [R05]
        else $error("dark interval did not relight");
    on_load_a: assert property ($rose(bus.lit) |-> cnt == $past(on_ticks)) // [R02]
        else $error("on count not loaded from on-time field");
    hold_no_tick_a: assert property (bus.enable && !bus.tick && bus.dark_code != 2'h0 // [R08]
        && phase != LSBT_IDLE |=> $stable(bus.lit))
        else $error("sink changed phase without a time-base tick");
endmodule : lsbt_sink
`default_nettype wire

// ===== logic/lsbt_top.sv
`timescale 1ns/1ps
`default_nettype none
module lsbt_top
    import lsbt_pkg::*;
#(
    parameter int TICK_CYCLES = LSBT_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic [7:0] low_dark_time,
    output logic [LSBT_SINKS-1:0] sink_on
);
    localparam int TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    logic [7:0] sink_enable;
    logic [7:0] blink_timing_one;
    logic [TW-1:0] tick_cnt;
    logic tick;

    // one time base for all sinks keeps the counter cost to a single wide register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
                tick_cnt <= '0;
                tick <= 1'b1; // [R08]
            end else begin
                tick_cnt <= tick_cnt + TW'(1);
                tick <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sink_enable <= LSBT_SINK_ENABLE_RESET;
        end else if (wr_en && wr_addr == LSBT_SINK_ENABLE_ADDR) begin
            sink_enable <= wr_data & LSBT_SINK_ENABLE_MASK; // [R07]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_timing_one <= LSBT_BLINK_TIMING_ONE_RESET;
        end else if (wr_en && wr_addr == LSBT_BLINK_TIMING_ONE_ADDR) begin
            blink_timing_one <= wr_data; // [R02] [R04]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            unique case (rd_addr)
                LSBT_SINK_ENABLE_ADDR: rd_data <= sink_enable; // [R07]
                LSBT_BLINK_TIMING_ONE_ADDR: rd_data <= blink_timing_one;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    for (genvar i = 0; i < LSBT_SINKS; i++) begin : g_sink
        lsbt_sink_if bus ();
        assign bus.tick = tick;
        assign bus.enable = sink_enable[i]; // [R01]
        assign bus.on_code = blink_timing_one[LSBT_ON_TIME_LSB +: LSBT_FIELD_W]; // [R02]
        if (i >= LSBT_FIRST_TIMED_SINK) begin : g_timed
            assign bus.dark_code =
                blink_timing_one[(i - LSBT_FIRST_TIMED_SINK) * LSBT_FIELD_W +: LSBT_FIELD_W]; // [R04]
        end else begin : g_low
            assign bus.dark_code = low_dark_time[i * LSBT_FIELD_W +: LSBT_FIELD_W];
        end
        lsbt_sink u_sink (
            .clk(clk),
            .rst_b(rst_b),
            .bus(bus.sink)
        );
        assign sink_on[i] = bus.lit;
    end

    enable_write_a: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
        wr_en && wr_addr == LSBT_SINK_ENABLE_ADDR |=> sink_enable == {1'b0, $past(wr_data[6:0])})
        else $error("sink enable write not stored with bit 7 clear");
    timing_write_a: assert property (@(posedge clk) disable iff (!rst_b) // [R02]
        wr_en && wr_addr == LSBT_BLINK_TIMING_ONE_ADDR |=> blink_timing_one == $past(wr_data))
        else $error("timing write not stored");
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
        tick |=> !tick ##0 tick_cnt == TW'(1))
        else $error("time base ticks too close");
    reserved_bit_a: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
        !sink_enable[7])
        else $error("reserved enable bit set");
    read_enable_a: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
        rd_en && rd_addr == LSBT_SINK_ENABLE_ADDR |=> rd_data == $past(sink_enable))
        else $error("enable register read wrong");
endmodule : lsbt_top
`default_nettype wire

// ===== dv/lsbt_host.sv
`timescale 1ns/1ps
`default_nettype none
module lsbt_host (
    input wire logic clk,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic [7:0] low_dark_time
);
    initial begin
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_en = 1'b0;
        rd_addr = 8'h00;
        low_dark_time = 8'h00;
    end

    // strobe and address stay up through the taking edge; the strobe is dropped by nba on it, the address is held
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= addr;
        wr_data <= data;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : write

    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= addr;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        #1;
        data = rd_data;
    endtask : read
endmodule : lsbt_host
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lsbt_pkg::*;
    localparam int TICK = 4;
    logic clk;
    logic rst_b;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] low_dark_time;
    logic [LSBT_SINKS-1:0] sink_on;
    logic [7:0] rv;
    logic [7:0] got;
    logic [1:0] d6;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'hcf6b787b;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    lsbt_top #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .low_dark_time(low_dark_time), .sink_on(sink_on));
    lsbt_host host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .low_dark_time(low_dark_time));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // phase lengths in 0.2 s ticks
    function automatic int on_ticks(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 3 : (c == 2'h2) ? 4 : 6;
    endfunction : on_ticks

    function automatic int dark_ticks(input logic [1:0] c);
        return 3 * int'(c);
    endfunction : dark_ticks

    // pass idle, the first lit phase (may be short) and a dark one, then time lit and dark
    task automatic blink(input int idx, input logic [1:0] on_c, input logic [1:0] off_c);
        int n;
        #1;
        for (int ph = 0; ph < 5; ph++) begin
            n = 0;
            while (sink_on[idx] === ph[0] && n < 100) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (ph == 3) check("lit_cycles", 16'(n), 16'(on_ticks(on_c) * TICK));
            if (ph == 4) check("dark_cycles", 16'(n), 16'(dark_ticks(off_c) * TICK));
        end
    endtask : blink

    task automatic finish_test;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        #250000;
        num_errors++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        host.read(8'h10, got);
        check("enable_reset", 16'(got), 16'h0000);
        host.read(8'h11, got);
        check("timing_reset", 16'(got), 16'h0000);
        host.write(8'h10, 8'hFF);
        host.write(8'h20, 8'hA5);
        host.read(8'h10, got);
        check("enable_reserved", 16'(got), 16'h007F);
        host.read(8'h20, got);
        check("unmapped", 16'(got), 16'h0000);
        rv = 8'($random(seed));
        host.write(8'h11, rv);
        host.read(8'h11, got);
        check("timing_rw", 16'(got), 16'(rv));
        host.write(8'h11, {rv[7:6], 6'h00});
        for (int k = 0; k < 6; k++) begin
            rv = 8'($random(seed)) & 8'h7F;
            if (k == 5) rv = 8'h7F;
            host.write(8'h10, rv);
            repeat (3) @(posedge clk);
            #1;
            check("steady_on", 16'(sink_on), 16'(rv));
        end
        for (int on = 0; on < 4; on++) begin
            for (int d = 1; d < 4; d++) begin
                rv = 8'($random(seed));
                d6 = 2'(d % 3 + 1);
                host.write(8'h10, 8'h00);
                host.low_dark_time <= {rv[7:2], 2'(d)};
                host.write(8'h11, {2'(on), 2'(d), d6, rv[1:0]});
                host.write(8'h10, 8'h7F);
                blink(6, 2'(on), 2'(d));
                blink(5, 2'(on), d6);
                blink(0, 2'(on), 2'(d));
                if (rv[1:0] == 2'h0) check("sink5_steady", 16'(sink_on[4]), 16'h0001);
                else blink(4, 2'(on), rv[1:0]);
                if (rv[7:6] != 2'h0) blink(3, 2'(on), rv[7:6]);
            end
        end
        // catch sink 7 at the start of a dark phase so the relight cannot be a natural one
        while (sink_on[6] !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        while (sink_on[6] !== 1'b0) begin
            @(posedge clk);
            #1;
        end
        check("dark_first", 16'(sink_on[6]), 16'h0000);
        host.write(8'h11, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        check("relight", 16'(sink_on[6]), 16'h0001);
        host.write(8'h10, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        check("all_off", 16'(sink_on), 16'h0000);
        finish_test();
    end
endmodule : tb
`default_nettype wire
